/* File: rke_code_word_assembler.sv */
// code word assembler: parameter store, cipher, framer, element fifo and pulse driver
module rke_code_word_assembler
   import rke_pkg::*;
#(
   parameter int TE_SLOW_CYC = TE_SLOW_NS / CLK_NS,
   parameter int TE_FAST_CYC = TE_FAST_NS / CLK_NS,
   parameter int ENC_ROUNDS  = 528,
   parameter int FIFO_DEPTH  = 16
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // button pins
   input  wire logic        button_input_0_in,
   input  wire logic        button_input_1_in,
   input  wire logic        button_input_2_in,
   // battery comparator pin
   input  wire logic        battery_below_in,
   // store programming port
   input  wire logic        store_wr_en_in,
   input  wire logic [3:0]  store_addr_in,
   input  wire logic [15:0] store_wdata_in,
   output logic [15:0]      store_rdata_out,
   // analog controls
   output logic [3:0]       osc_trim_out,
   output logic [1:0]       trip_level_out,
   // transmit side
   output logic             data_out,
   output logic             tx_active_out
);
   localparam int TE_W = $clog2(TE_SLOW_CYC + 1);
   localparam int RW   = $clog2(ENC_ROUNDS + 1);

   logic [15:0]      store_r [STORE_WORDS];
   logic [2:0]       btn_meta_r;
   logic [2:0]       btn_r;
   logic             bat_meta_r;
   logic             battery_low_flag_r;
   state_t           state_r;
   seg_t             seg_r;
   logic [2:0]       btn_cap_r;
   logic [31:0]      blk_r;
   logic [63:0]      key_r;
   logic [RW-1:0]    rnd_r;
   logic [65:0]      payload_r;
   logic [7:0]       cnt_r;
   logic [6:0]       bit_r;
   logic [1:0]       ph_r;
   logic             first_r;
   logic             parity_r;
   logic             blank_r;
   logic [2:0]       sent_r;
   logic [3:0]       osc_trim_r;
   logic [1:0]       trip_r;
   logic [15:0]      rdata_r;
   logic             data_r;
   logic             active_r;
   logic [TE_W-1:0]  te_cnt_r;

   // option fields; unused upper bits are never looked at
   wire [15:0] opt         = store_r[ADDR_OPT];
   wire rate_select        = opt[OPT_RATE];
   wire minimum_four_words = opt[OPT_MIN4];
   wire start_pulse_enable = opt[OPT_START];
   wire fb3_setting        = opt[OPT_FB3];
   wire extended_serial    = opt[OPT_EXTENDED_SERIAL_OPTION];
   wire [63:0] key_word    = {store_r[ADDR_KEY3], store_r[2], store_r[1],
                              store_r[ADDR_KEY0]};
   wire [31:0] serial      = {store_r[ADDR_SER_HI], store_r[ADDR_SER_LO]};
   wire [31:0] learn_value = {store_r[ADDR_LRN_HI], store_r[ADDR_LRN_LO]};
   wire [11:0] check_bits  = store_r[ADDR_CHECK][CHECK_MSB:0];
   wire [15:0] counter     = store_r[ADDR_CNT];
   wire [15:0] counter_inc = counter + 16'h0001;

   // function code; fourth bit mirrors button 2 unless forced
   wire function_bit_three = fb3_setting | btn_r[2];
   wire [3:0] func        = {function_bit_three, btn_r};
   wire [31:0] plain      = {func, check_bits, counter};
   wire [31:0] plain_inc  = {func, check_bits, counter_inc};
   wire learn_req         = &btn_cap_r;
   wire [1:0] status      = {~first_r, battery_low_flag_r};
   // fixed part uses the captured buttons: the pins may be released before the load
   wire [3:0] func_cap    = {fb3_setting | btn_cap_r[2], btn_cap_r};
   wire [33:0] fixed      = extended_serial ? {status, serial}
                          : {status, func_cap, serial[SER_SHORT-1:0]};
   wire [31:0] enc_part   = learn_req ? learn_value : blk_r;
   wire new_button        = |(btn_r & ~btn_cap_r);
   wire busy              = (state_r != ST_IDLE);

   // cipher step: nonlinear feedback shift under a rotating key
   wire nl_bit = (blk_r[1] & blk_r[9]) ^ (blk_r[20] | blk_r[26]) ^
                 (blk_r[31] & ~blk_r[14]);
   wire fb_bit = nl_bit ^ blk_r[0] ^ blk_r[16] ^ key_r[0];
   wire rnd_last = (rnd_r == RW'(ENC_ROUNDS - 1));

   // element level for the current framing position
   logic sym_level;
   always_comb begin
      case (seg_r)
         SEG_START: sym_level = (cnt_r == 8'd0);
         SEG_PRE:   sym_level = ~cnt_r[0];
         SEG_DATA:  sym_level = (ph_r == 2'd0) ? 1'b1 :
                                (ph_r == 2'd1) ? ~payload_r[0] : 1'b0;
         default:   sym_level = 1'b0;
      endcase
   end
   wire fifo_ready;
   wire push       = (state_r == ST_SEND);
   wire step       = push & fifo_ready;
   wire seg_end    = (seg_r == SEG_START) ? (cnt_r == START_TE - 8'd1) :
                     (seg_r == SEG_PRE)   ? (cnt_r == PRE_TE - 8'd1) :
                     (seg_r == SEG_HDR)   ? (cnt_r == HDR_TE - 8'd1) :
                     (seg_r == SEG_GUARD) ? (cnt_r == GUARD_TE - 8'd1) :
                     ((bit_r == LAST_BIT) && (ph_r == LAST_PH));
   wire word_end   = step & seg_end & (seg_r == SEG_GUARD);
   wire [2:0] sent_nxt = (blank_r || sent_r == MIN_WORDS) ? sent_r
                         : sent_r + 3'd1;
   wire more       = (|btn_r) | (minimum_four_words & (sent_nxt < MIN_WORDS));

   // drain side of the element fifo
   wire       fifo_valid;
   wire       fifo_level;
   wire       drain_ready = (te_cnt_r == '0);
   wire [TE_W-1:0] te_len = rate_select ? TE_W'(TE_FAST_CYC - 1)
                                        : TE_W'(TE_SLOW_CYC - 1);

   rke_fifo #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (push),
      .in_ready_out  (fifo_ready),
      .in_data_in    (sym_level & ~blank_r),
      .out_valid_out (fifo_valid),
      .out_ready_in  (drain_ready),
      .out_data_out  (fifo_level)
   );

   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         btn_meta_r         <= 3'h0;
         btn_r              <= 3'h0;
         bat_meta_r         <= 1'b0;
         battery_low_flag_r <= 1'b0;
      end else begin
         btn_meta_r         <= {button_input_2_in, button_input_1_in, button_input_0_in};
         btn_r              <= btn_meta_r;
         bat_meta_r         <= battery_below_in;
         battery_low_flag_r <= bat_meta_r;
      end
   end

   // parameter store; programming only while idle, spare word stays zero
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < STORE_WORDS; i++) begin
            store_r[i] <= WORD_RESET;
         end
      end else if (!busy && store_wr_en_in && store_addr_in != ADDR_SPARE
                   && store_addr_in <= ADDR_OPT) begin
         store_r[store_addr_in] <= store_wdata_in;
      end else if ((state_r == ST_DONE) ||
                   (busy && state_r != ST_DONE && new_button)) begin
         store_r[ADDR_CNT] <= counter_inc;
      end
   end

   // readback: key words are write-only and read as zero
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_r <= WORD_RESET;
      end else if (store_addr_in <= ADDR_KEY3 || store_addr_in > ADDR_OPT) begin
         rdata_r <= WORD_RESET;
      end else begin
         rdata_r <= store_r[store_addr_in];
      end
   end

   // analog settings follow the option word
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_trim_r <= 4'h0;
         trip_r     <= TRIP_4V4;
      end else begin
         osc_trim_r <= opt[OPT_TRIM_MSB:OPT_TRIM_LSB];
         trip_r     <= !opt[OPT_BAT_SEL] ? TRIP_4V4 :
                       fb3_setting ? TRIP_6V75 : TRIP_9V;
      end
   end

   // main sequencer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r   <= ST_IDLE;
         seg_r     <= SEG_PRE;
         btn_cap_r <= 3'h0;
         blk_r     <= 32'h0000_0000;
         key_r     <= 64'h0000_0000_0000_0000;
         rnd_r     <= '0;
         payload_r <= '0;
         cnt_r     <= 8'h00;
         bit_r     <= 7'h00;
         ph_r      <= 2'h0;
         first_r   <= 1'b1;
         parity_r  <= 1'b0;
         blank_r   <= 1'b0;
         sent_r    <= 3'h0;
      end else if (busy && state_r != ST_DONE && new_button) begin
         // a newly pressed button restarts with fresh button data
         state_r   <= ST_ENCRYPT;
         btn_cap_r <= btn_r;
         blk_r     <= plain_inc;
         key_r     <= key_word;
         rnd_r     <= '0;
         first_r   <= 1'b1;
         parity_r  <= 1'b0;
         sent_r    <= 3'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (|btn_r) begin
                  state_r   <= ST_ENCRYPT;
                  btn_cap_r <= btn_r;
                  blk_r     <= plain;
                  key_r     <= key_word;
                  rnd_r     <= '0;
                  first_r   <= 1'b1;
                  parity_r  <= 1'b0;
                  sent_r    <= 3'h0;
               end
            end
            ST_ENCRYPT: begin
               blk_r <= {fb_bit, blk_r[31:1]};
               key_r <= {key_r[0], key_r[63:1]};
               rnd_r <= rnd_r + 1'b1;
               if (rnd_last) state_r <= ST_LOAD;
            end
            ST_LOAD: begin
               payload_r <= {fixed, enc_part};
               seg_r     <= (start_pulse_enable && first_r) ? SEG_START : SEG_PRE;
               cnt_r     <= 8'h00;
               bit_r     <= 7'h00;
               ph_r      <= 2'h0;
               blank_r   <= rate_select & parity_r;
               state_r   <= ST_SEND;
            end
            ST_SEND: begin
               if (step) begin
                  cnt_r <= seg_end ? 8'h00 : cnt_r + 8'd1;
                  if (seg_r == SEG_DATA) begin
                     ph_r <= (ph_r == LAST_PH) ? 2'h0 : ph_r + 2'd1;
                     if (ph_r == LAST_PH) begin
                        payload_r <= {1'b0, payload_r[65:1]};
                        bit_r     <= bit_r + 7'd1;
                     end
                  end
                  if (seg_end) begin
                     case (seg_r)
                        SEG_START: seg_r <= SEG_PRE;
                        SEG_PRE:   seg_r <= SEG_HDR;
                        SEG_HDR:   seg_r <= SEG_DATA;
                        SEG_DATA:  seg_r <= SEG_GUARD;
                        default:   seg_r <= SEG_PRE;
                     endcase
                  end
                  if (word_end) begin
                     sent_r   <= sent_nxt;
                     parity_r <= ~parity_r;
                     first_r  <= 1'b0;
                     state_r  <= more ? ST_LOAD : ST_DONE;
                  end
               end
            end
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // pulse driver: each element holds the pin for one element time
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         te_cnt_r <= '0;
         data_r   <= 1'b0;
         active_r <= 1'b0;
      end else begin
         active_r <= busy | fifo_valid | !drain_ready;
         if (drain_ready) begin
            data_r   <= fifo_valid & fifo_level;
            te_cnt_r <= fifo_valid ? te_len : '0;
         end else begin
            te_cnt_r <= te_cnt_r - 1'b1;
         end
      end
   end

   assign store_rdata_out = rdata_r;
   assign osc_trim_out    = osc_trim_r;
   assign trip_level_out  = trip_r;
   assign data_out        = data_r;
   assign tx_active_out   = active_r;
endmodule : rke_code_word_assembler

// element fifo between the framer and the pulse driver
module rke_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push = in_valid_in & in_ready_out;
   wire              pop  = out_valid_out & out_ready_in;

   // full compare at the count's own width, so a depth of 2**AW is not folded to zero
   assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
   assign out_valid_out = (count_r != '0);
   assign out_data_out  = mem_r[rd_ptr_r];

   // storage carries no reset, only pointers and count do
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end

   // pointers wrap naturally for power-of-two depths
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : rke_fifo

/* File: rke_code_word_assembler_bench.sv */
// self-checking bench for the code word assembler
module rke_code_word_assembler_bench
   import rke_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TE_S = 8;
   localparam int TE_F = 4;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [2:0]  btn = 3'h0;
   logic        batt = 1'b0;
   logic        wr_en = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic [3:0]  trim;
   logic [1:0]  trip;
   logic        pin;
   logic        active;
   int          te = TE_S;
   int          error_cnt = 0;
   int          n_tests = 0;
   logic [31:0] ser = 32'hA5C3_1E7D;
   logic [31:0] lrn = 32'h3C96_0F5B;

   always #2 clk_in = ~clk_in;

   rke_code_word_assembler #(.TE_SLOW_CYC(TE_S), .TE_FAST_CYC(TE_F), .ENC_ROUNDS(8),
      .FIFO_DEPTH(16)) i_dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .button_input_0_in(btn[0]),
      .button_input_1_in(btn[1]), .button_input_2_in(btn[2]), .battery_below_in(batt),
      .store_wr_en_in(wr_en), .store_addr_in(addr), .store_wdata_in(wdata),
      .store_rdata_out(rdata), .osc_trim_out(trim), .trip_level_out(trip),
      .data_out(pin), .tx_active_out(active));
   rke_rx_model i_rx (.clk_in(clk_in), .rst_n_in(rst_n_in), .data_in(pin),
      .active_in(active), .te_in(te));

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // store port: one strobe cycle, address held one more cycle for readback
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(negedge clk_in);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk_in);
      wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(negedge clk_in);
      addr = a;
      repeat (3) @(negedge clk_in);
      chk(32'(rdata), 32'(exp));
   endtask : rd

   // bounded wait on the transmit state; a hang ends the run
   task automatic wait_for(input logic lvl, input int bound);
      int n;
      n = 0;
      while (active !== lvl && n < bound) begin
         @(negedge clk_in);
         n++;
      end
      if (active !== lvl) begin
         error_cnt++;
         $display("mismatch at %0t: transmit state stuck", $time);
         tally_and_finish();
      end
   endtask : wait_for

   // data bit k sits in the middle element of its three, lsb first
   function automatic logic [31:0] fld(input int off, input int lo, input int n);
      logic [31:0] v;
      v = '0;
      for (int k = 0; k < n; k++) begin
         v[k] = ~i_rx.elems[off + 34 + 3 * (lo + k)];
      end
      return v;
   endfunction : fld

   // one activation, judged on framing, status bits and the counter step
   task automatic send(input logic [15:0] opt, input logic [2:0] b, input logic bv);
      logic [15:0] cnt;
      int          off;
      logic        hdr;
      off = opt[OPT_START] ? 2 : 0;
      te = opt[OPT_RATE] ? TE_F : TE_S;
      wr(ADDR_OPT, opt);
      addr = ADDR_CNT;
      repeat (2) @(negedge clk_in);
      cnt = rdata;
      batt = bv;
      btn = b;
      wait_for(1'b1, 200);
      btn = 3'h0;
      wait_for(1'b0, 8000);
      repeat (4) @(negedge clk_in);
      hdr = 1'b0;
      for (int k = 23; k < 33; k++) begin
         hdr |= i_rx.elems[off + k];
      end
      chk(32'(i_rx.first_hi), 32'(te));
      chk(32'({i_rx.elems[off + 22], hdr}), 32'h2);
      chk(32'(i_rx.n_elem), 32'(off + 270));
      chk(fld(off, 64, 2), 32'(bv));
      chk(32'(rdata), 32'(cnt + 16'h0001));
   endtask : send

   task automatic s_reset_state();
      for (int a = 0; a < 16; a++) begin
         rd(a[3:0], WORD_RESET);
      end
      chk(32'({trim, trip}), 32'h0);
   endtask : s_reset_state

   task automatic s_store_map();
      logic [15:0] d;
      logic [1:0]  exp_trip [4] = '{TRIP_4V4, TRIP_9V, TRIP_4V4, TRIP_6V75};
      for (int a = 0; a < 16; a++) begin
         d = 16'h5A00 | 16'(a);
         wr(a[3:0], d);
         rd(a[3:0], (a == 4 || (a > 5 && a < 12)) ? d : WORD_RESET);
      end
      chk(32'(trim), 32'hB);
      // unused option bits stay set to show they are ignored
      for (int i = 0; i < 4; i++) begin
         d = 16'hFC00 | (16'(i[1]) << OPT_FB3) | (16'(i[0]) << OPT_BAT_SEL);
         wr(ADDR_OPT, d);
         rd(ADDR_OPT, d);
         chk(32'(trip), 32'(exp_trip[i]));
      end
   endtask : s_store_map

   task automatic s_short_serial();
      wr(ADDR_SER_LO, ser[15:0]);
      wr(ADDR_SER_HI, ser[31:16]);
      send(16'h0180, 3'h1, 1'b0);
      chk(fld(2, 32, 28), 32'(ser[27:0]));
      chk(fld(2, 60, 4), 32'h9);
   endtask : s_short_serial

   task automatic s_long_serial();
      send(16'h0220, 3'h2, 1'b1);
      chk(fld(0, 32, 32), ser);
   endtask : s_long_serial

   // four-word minimum at the fast rate: seven words, every second one blanked
   task automatic s_four_words();
      int n;
      te = TE_F;
      wr(ADDR_OPT, 16'h0060);
      btn = 3'h1;
      wait_for(1'b1, 200);
      btn = 3'h0;
      n = 0;
      while (active === 1'b1 && n < 9000) begin
         @(negedge clk_in);
         n++;
      end
      wait_for(1'b0, 1);
      chk(32'(n >= 7 * 270 * TE_F && n < 8 * 270 * TE_F), 32'h1);
      chk(32'(i_rx.elems[270]), 32'h0);
   endtask : s_four_words

   task automatic s_learn();
      wr(ADDR_LRN_LO, lrn[15:0]);
      wr(ADDR_LRN_HI, lrn[31:16]);
      send(16'h0000, 3'h7, 1'b0);
      chk(fld(0, 0, 32), lrn);
      chk(fld(0, 60, 4), 32'hF);
   endtask : s_learn

   // main sequence
   initial begin
      repeat (6) @(negedge clk_in);
      rst_n_in = 1'b1;
      @(negedge clk_in);
      s_reset_state();
      s_store_map();
      s_short_serial();
      s_long_serial();
      s_four_words();
      s_learn();
      tally_and_finish();
   end
endmodule : rke_code_word_assembler_bench

/* File: rke_cwa_props.sv */
// port checks for the code word assembler
module rke_cwa_props
   import rke_pkg::*;
#(
   parameter int TE_SLOW_CYC = 8,
   parameter int TE_FAST_CYC = 4
) (
   // clock and reset
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   // store port
   input wire logic        store_wr_en_in,
   input wire logic [3:0]  store_addr_in,
   input wire logic [15:0] store_wdata_in,
   input wire logic [15:0] store_rdata_out,
   // controls and pin
   input wire logic [3:0]  osc_trim_out,
   input wire logic [1:0]  trip_level_out,
   input wire logic        data_out,
   input wire logic        tx_active_out
);
   int        hi_len_r;
   int        lo_len_r;
   wire logic bat_w = store_rdata_out[OPT_BAT_SEL];
   wire logic fb3_w = store_rdata_out[OPT_FB3];

   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // run lengths of the pin level, so element widths can be judged when a level ends
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hi_len_r <= 0;
         lo_len_r <= 0;
      end else begin
         hi_len_r <= data_out ? hi_len_r + 1 : 0;
         lo_len_r <= data_out ? 0 : lo_len_r + 1;
      end
   end

   AST_ELEM_WIDTH: assert property (
      $fell(data_out) |-> hi_len_r inside {TE_SLOW_CYC, 2 * TE_SLOW_CYC,
                                           TE_FAST_CYC, 2 * TE_FAST_CYC})
      else $error("high level of the pin is not a whole number of elements");
   AST_GUARD_LOW: assert property (
      $fell(tx_active_out) |-> lo_len_r >= int'(GUARD_TE) * TE_FAST_CYC)
      else $error("transmission ended without a full guard period");
   AST_PIN_IN_TX: assert property (
      data_out |-> tx_active_out)
      else $error("pin high outside a transmission");
   AST_RESET_QUIET: assert property (
      $rose(rst_n_in) |-> !data_out && !tx_active_out && trip_level_out == TRIP_4V4)
      else $error("outputs not quiet on the first edge after reset");
   AST_TRIP_TABLE: assert property (
      (store_addr_in == ADDR_OPT && !store_wr_en_in) [*3]
      |-> trip_level_out == {fb3_w & bat_w, bat_w & !fb3_w})
      else $error("trip level does not match the option word");
   AST_TRIM_FOLLOWS: assert property (
      (store_addr_in == ADDR_OPT && !store_wr_en_in) [*3]
      |-> osc_trim_out == store_rdata_out[OPT_TRIM_MSB:OPT_TRIM_LSB])
      else $error("trim output does not match the option word");
   AST_SPARE_ZERO: assert property (
      (store_addr_in == ADDR_SPARE) [*2] |-> store_rdata_out == WORD_RESET)
      else $error("spare word reads non-zero");
   AST_KEY_HIDDEN: assert property (
      (store_addr_in <= ADDR_KEY3) ##1 (store_addr_in <= ADDR_KEY3)
      |-> store_rdata_out == WORD_RESET)
      else $error("key word visible on readback");
   AST_WRITE_READBACK: assert property (
      store_wr_en_in && !tx_active_out && (store_addr_in == ADDR_CNT ||
      (store_addr_in >= ADDR_SER_LO && store_addr_in <= ADDR_OPT))
      ##1 (!store_wr_en_in && $stable(store_addr_in))
      |=> store_rdata_out == $past(store_wdata_in, 2))
      else $error("written store word not read back");
endmodule : rke_cwa_props

bind rke_code_word_assembler rke_cwa_props #(
   .TE_SLOW_CYC(TE_SLOW_CYC),
   .TE_FAST_CYC(TE_FAST_CYC)
) i_props (
   .clk_in(clk_in),
   .rst_n_in(rst_n_in),
   .store_wr_en_in(store_wr_en_in),
   .store_addr_in(store_addr_in),
   .store_wdata_in(store_wdata_in),
   .store_rdata_out(store_rdata_out),
   .osc_trim_out(osc_trim_out),
   .trip_level_out(trip_level_out),
   .data_out(data_out),
   .tx_active_out(tx_active_out)
);

/* File: rke_fifo.sv */
// the element fifo module sits beside the assembler in its design file

/* File: rke_pkg.sv */
// shared constants and types for the code word assembler
package rke_pkg;
   // parameter store layout
   localparam int        STORE_WORDS  = 12;
   localparam int        WORD_W       = 16;
   localparam logic [3:0] ADDR_KEY0   = 4'h0;
   localparam logic [3:0] ADDR_KEY3   = 4'h3;
   localparam logic [3:0] ADDR_CNT    = 4'h4;
   localparam logic [3:0] ADDR_SPARE  = 4'h5;
   localparam logic [3:0] ADDR_SER_LO = 4'h6;
   localparam logic [3:0] ADDR_SER_HI = 4'h7;
   localparam logic [3:0] ADDR_LRN_LO = 4'h8;
   localparam logic [3:0] ADDR_LRN_HI = 4'h9;
   localparam logic [3:0] ADDR_CHECK  = 4'hA;
   localparam logic [3:0] ADDR_OPT    = 4'hB;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // option word fields
   localparam int OPT_TRIM_LSB = 0;
   localparam int OPT_TRIM_MSB = 3;
   localparam int OPT_BAT_SEL  = 4;
   localparam int OPT_RATE     = 5;
   localparam int OPT_MIN4     = 6;
   localparam int OPT_START    = 7;
   localparam int OPT_FB3      = 8;
   localparam int OPT_EXTENDED_SERIAL_OPTION     = 9;
   localparam int CHECK_MSB    = 11;
   // code word layout
   localparam int ENC_BITS   = 32;
   localparam int FIXED_BITS = 34;
   localparam int DATA_BITS  = 66;
   localparam int SER_SHORT  = 28;
   localparam logic [6:0] LAST_BIT   = 7'd65;
   localparam logic [2:0] MIN_WORDS  = 3'd4;
   // element counts of the framing segments
   localparam logic [7:0] START_TE = 8'd2;
   localparam logic [7:0] PRE_TE   = 8'd23;
   localparam logic [7:0] HDR_TE   = 8'd10;
   localparam logic [7:0] GUARD_TE = 8'd39;
   localparam logic [1:0] LAST_PH  = 2'd2;
   // timing
   localparam int CLK_NS     = 4;
   localparam int TE_SLOW_NS = 400000;
   localparam int TE_FAST_NS = 200000;
   // low-battery trip level codes
   localparam logic [1:0] TRIP_4V4  = 2'b00;
   localparam logic [1:0] TRIP_9V   = 2'b01;
   localparam logic [1:0] TRIP_6V75 = 2'b10;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ENCRYPT = 3'b001,
      ST_LOAD    = 3'b010,
      ST_SEND    = 3'b011,
      ST_DONE    = 3'b100
   } state_t;

   typedef enum logic [2:0] {
      SEG_START = 3'b000,
      SEG_PRE   = 3'b001,
      SEG_HDR   = 3'b010,
      SEG_DATA  = 3'b011,
      SEG_GUARD = 3'b100
   } seg_t;
endpackage : rke_pkg

/* File: rke_rx_model.sv */
// receiver model: samples the first 300 elements of the pulse stream, each at its centre
module rke_rx_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // observed pins
   input wire logic data_in,
   input wire logic active_in,
   input wire logic [31:0] te_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic elems [0:299];
   int   n_elem;
   int   first_hi;
   int   cyc;
   logic run;

   // capture opens on the first high level and closes when the sender goes quiet
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run = 1'b0;
         n_elem = 0;
      end else if (!run && data_in && active_in) begin
         run = 1'b1;
         cyc = 0;
         n_elem = 0;
         first_hi = 0;
      end else if (run && !active_in) begin
         run = 1'b0;
      end
      if (run) begin
         if (data_in && first_hi == cyc) begin
            first_hi++;
         end
         // centre sampling tolerates a one-cycle skew at either end of an element
         if (cyc % te_in == te_in / 2 && n_elem < 300) begin
            elems[n_elem] = data_in;
            n_elem++;
         end
         cyc++;
      end
   end
endmodule : rke_rx_model
